// file: core/mcu_address_space.sv
/*
  Program address generator, register file and register-file stack.
  Assumes the core, the program ROM (combinational read of prog_addr_o)
  and this block share clk_i; nothing here crosses a clock domain.
*/
`timescale 1ns/10ps

// How it works
// [RULE_01] Program address is twelve bits, 0 to FFF
// [RULE_02] Register file has its own 8-bit bus
// [RULE_03] Lowest 256 program bytes hold vectors
// [RULE_04] Cells 3C-3F are options, never code
// [RULE_05] Programmer fills unused option cells with FF
// [RULE_06] First fetch after reset is at 0100
// [RULE_07] 00-BF general space, single page only
// [RULE_08] Upper 64 hold working and control registers
// [RULE_09] 208 storage bytes, 34 control locations
// [RULE_10] Working register n lives at C0 plus n
// [RULE_11] Direct C0-CF addressing is invalid for software
// [RULE_12] Pairs start even, MSB at even address
// [RULE_13] Call pushes counter, return pops it
// [RULE_14] Interrupt pushes counter and flags, return pops both
// [RULE_15] Decrement before push, increment after pop
// [RULE_16] Stack pointer at D9, not reset
// [RULE_17] Stack pointer wraps modulo 256
// [RULE_18] Software loads pointer 00-C0, C0 preferred
module mcu_address_space (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire mcu_space_pkg::reg_req_t  req_i,
  input  wire mcu_space_pkg::ctl_req_t  ctl_i,
  input  wire logic [7:0]               flags_i,
  input  wire logic [7:0]               rom_data_i,
  output logic [15:0]                   rdata_o,
  output logic                          rvalid_o,
  output logic [11:0]                   prog_addr_o,
  output logic [7:0]                    flags_o,
  output logic                          flags_load_o,
  output logic                          busy_o,
  output logic                          addr_err_o,
  output logic [7:0]                    option_low_voltage_reset_o,
  output logic [7:0]                    option_osc_o
);

  ////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [7:0]            mem [mcu_space_pkg::GP_COUNT];  // 00-CF only
  logic [7:0]            sp;          // Stack pointer byte, no reset
  logic [11:0]           program_counter;  // Address of the next program byte
  logic [11:0]           save_counter;     // Return address held during push
  logic [7:0]            save_flags;  // Flags held during push
  logic [1:0]            step;        // Byte index within a frame
  logic [1:0]            last;        // Index of the final frame byte
  mcu_space_pkg::state_t state;
  mcu_space_pkg::state_t next_state;

  // Index of the final byte of each frame kind
  localparam logic [1:0] INT_LAST  = mcu_space_pkg::INT_BYTES - 2'h1;
  localparam logic [1:0] CALL_LAST = mcu_space_pkg::CALL_BYTES - 2'h1;

  // Location holds a storage byte (general space plus working area)
  function automatic logic in_store(input logic [7:0] a);
    in_store = a <= mcu_space_pkg::WORK_TOP;  // see [RULE_09]
  endfunction : in_store

  // Read one register-file byte; unimplemented control locations read 0
  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input logic [7:0] s);
    if (a == mcu_space_pkg::SP_ADDR) begin
      rd_byte = s;  // see [RULE_16]
    end else if (a <= mcu_space_pkg::WORK_TOP) begin
      rd_byte = mem[a];
    end else begin
      rd_byte = 8'h00;
    end
  endfunction : rd_byte

  ////////////////////////////////////////////////////////////////////////
  // Register bus decode

  wire       run     = state == mcu_space_pkg::S_RUN;
  wire       access  = run && (req_i.wr || req_i.rd);
  // Working form always lands in the common area
  wire [7:0] ea      = req_i.wreg ? {4'hC, req_i.addr[3:0]} : req_i.addr;  // see [RULE_10]
  wire [7:0] ea_odd  = {ea[7:1], 1'b1};
  wire       in_work = req_i.addr >= mcu_space_pkg::WORK_BASE &&
                       req_i.addr <= mcu_space_pkg::WORK_TOP;
  // Plain address into the working area is flagged and dropped
  wire       bad_form = !req_i.wreg && in_work;  // see [RULE_11]
  wire       bad_pair = req_i.pair && ea[0];     // see [RULE_12]
  wire       bus_bad  = access && (bad_form || bad_pair);
  wire       bus_wr   = run && req_i.wr && !bad_form && !bad_pair;
  wire       bus_rd   = run && req_i.rd && !bad_form && !bad_pair;
  // Only storage bytes and the stack pointer accept writes
  wire       wr_sp    = bus_wr && !req_i.pair && ea == mcu_space_pkg::SP_ADDR;  // see [RULE_16]
  wire       wr_hi    = bus_wr && in_store(ea);                                   // see [RULE_08]
  wire       wr_lo    = bus_wr && req_i.pair && in_store(ea_odd);

  ////////////////////////////////////////////////////////////////////////
  // Program fetch decode

  wire push_cmd  = run && (ctl_i.call || ctl_i.intr);
  wire pop_cmd   = run && !push_cmd && (ctl_i.subroutine_return || ctl_i.interrupt_return);
  // Option cells sit inside the vector area and are never executed;
  // only a fetch that really advances the counter can reach one
  wire fetch_opt = run && ctl_i.fetch && !push_cmd && !pop_cmd && !ctl_i.jump &&
                   program_counter >= mcu_space_pkg::OPT_FIRST &&
                   program_counter <= mcu_space_pkg::OPT_LAST;  // see [RULE_04]
  wire frame_end = step == last;

  ////////////////////////////////////////////////////////////////////////
  // Stack byte selection

  // Frame order pushed: counter low, counter high, flags; pops reverse it
  wire [1:0] pop_idx  = last - step;
  wire [7:0] push_byte = step == 2'h0 ? save_counter[7:0] :
                         step == 2'h1 ? {4'h0, save_counter[11:8]} : save_flags;  // see [RULE_12]
  wire [7:0] push_addr = sp - 8'h01;  // see [RULE_15]
  wire [7:0] pop_byte  = rd_byte(sp, sp);

  ////////////////////////////////////////////////////////////////////////
  // State sequencing

  // Boot reads both option cells, then starts the program
  always_comb begin
    next_state = state;
    case (state)
      mcu_space_pkg::S_BOOT_E: begin
        next_state = mcu_space_pkg::S_BOOT_F;
      end
      mcu_space_pkg::S_BOOT_F: begin
        next_state = mcu_space_pkg::S_RUN;
      end
      mcu_space_pkg::S_RUN: begin
        if (push_cmd) begin
          next_state = mcu_space_pkg::S_PUSH;
        end else if (pop_cmd) begin
          next_state = mcu_space_pkg::S_POP;
        end
      end
      mcu_space_pkg::S_PUSH, mcu_space_pkg::S_POP: begin
        if (frame_end) begin
          next_state = mcu_space_pkg::S_RUN;
        end
      end
      default: begin
        next_state = mcu_space_pkg::S_BOOT_E;
      end
    endcase
  end

  // State register and busy flag
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state  <= mcu_space_pkg::S_BOOT_E;
      busy_o <= 1'b1;
    end else begin
      state  <= next_state;
      busy_o <= next_state != mcu_space_pkg::S_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter and frame bookkeeping

  // Counter wraps inside the 4-Kbyte space by its own width
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      program_counter            <= mcu_space_pkg::OPT_LOW_VOLTAGE_RESET;
      step                       <= 2'h0;
      last                       <= 2'h0;
      save_counter               <= 12'h000;
      save_flags                 <= 8'h00;
      option_low_voltage_reset_o <= mcu_space_pkg::OPT_ERASED;
      option_osc_o               <= mcu_space_pkg::OPT_ERASED;
      flags_o                    <= 8'h00;
      flags_load_o               <= 1'b0;
    end else begin
      flags_load_o <= 1'b0;
      case (state)
        mcu_space_pkg::S_BOOT_E: begin
          option_low_voltage_reset_o <= rom_data_i;  // see [RULE_04]
          program_counter            <= mcu_space_pkg::OPT_OSC;
        end
        mcu_space_pkg::S_BOOT_F: begin
          option_osc_o    <= rom_data_i;  // see [RULE_04]
          program_counter <= mcu_space_pkg::RESET_ENTRY;  // see [RULE_06]
        end
        mcu_space_pkg::S_RUN: begin
          step <= 2'h0;
          if (push_cmd) begin
            // Core has already advanced the counter to the return point
            save_counter    <= program_counter;  // see [RULE_13]
            save_flags      <= flags_i;  // see [RULE_14]
            last            <= ctl_i.intr ? INT_LAST : CALL_LAST;
            program_counter <= ctl_i.target;
          end else if (pop_cmd) begin
            last <= ctl_i.interrupt_return ? INT_LAST : CALL_LAST;
          end else if (ctl_i.jump) begin
            program_counter <= ctl_i.target;
          end else if (ctl_i.fetch) begin
            // Vector area below 100 runs as code except option cells
            program_counter <= fetch_opt ? mcu_space_pkg::RESET_ENTRY : program_counter + 12'h001;  // see [RULE_03]
          end
        end
        mcu_space_pkg::S_PUSH: begin
          step <= step + 2'h1;
        end
        mcu_space_pkg::S_POP: begin
          step <= step + 2'h1;
          if (pop_idx == 2'h2) begin
            flags_o      <= pop_byte;  // see [RULE_14]
            flags_load_o <= 1'b1;
          end else if (pop_idx == 2'h1) begin
            program_counter[11:8] <= pop_byte[3:0];  // see [RULE_13]
          end else begin
            program_counter[7:0] <= pop_byte;
          end
        end
        default: begin
          step <= 2'h0;
        end
      endcase
    end
  end

  assign prog_addr_o = program_counter;  // see [RULE_01]

  ////////////////////////////////////////////////////////////////////////
  // Stack pointer

  // Left without reset on purpose: software must load it before use
  always_ff @(posedge clk_i) begin
    if (wr_sp) begin
      sp <= req_i.wdata[7:0];  // see [RULE_16]
    end else if (state == mcu_space_pkg::S_PUSH) begin
      sp <= push_addr;  // see [RULE_15] see [RULE_17]
    end else if (state == mcu_space_pkg::S_POP) begin
      sp <= sp + 8'h01;  // see [RULE_15]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file storage

  // One page only; a push outside storage (pointer wrapped) is lost
  always_ff @(posedge clk_i) begin
    if (state == mcu_space_pkg::S_PUSH && in_store(push_addr)) begin
      mem[push_addr] <= push_byte;  // see [RULE_07] see [RULE_13]
    end
    if (wr_hi) begin
      mem[ea] <= req_i.pair ? req_i.wdata[15:8] : req_i.wdata[7:0];  // see [RULE_07] see [RULE_12]
    end
    if (wr_lo) begin
      mem[ea_odd] <= req_i.wdata[7:0];  // see [RULE_12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bus answer

  // Read data registered one cycle after the request
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o    <= 16'h0000;
      rvalid_o   <= 1'b0;
      addr_err_o <= 1'b0;
    end else begin
      rvalid_o   <= bus_rd;  // see [RULE_02]
      addr_err_o <= bus_bad || fetch_opt;
      if (bus_rd) begin
        rdata_o <= req_i.pair ? {rd_byte(ea, sp), rd_byte(ea_odd, sp)} : {8'h00, rd_byte(ea, sp)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  a_reset_entry: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_06]
    $past(state) == mcu_space_pkg::S_BOOT_F && run |-> prog_addr_o == mcu_space_pkg::RESET_ENTRY)
    else $error("first fetch not at reset address");

  a_push_dec: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_15]
    state == mcu_space_pkg::S_PUSH |=> sp == $past(sp) - 8'h01)
    else $error("push did not decrement pointer");

  a_pop_inc: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_15]
    state == mcu_space_pkg::S_POP |=> sp == $past(sp) + 8'h01)
    else $error("pop did not increment pointer");

  a_sp_wrap: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_17]
    state == mcu_space_pkg::S_PUSH && sp == 8'h00 |=> sp == 8'hFF)
    else $error("pointer did not wrap to FF");

  a_call_frame: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_13]
    run && ctl_i.call && !ctl_i.intr |=> state == mcu_space_pkg::S_PUSH [*2] ##1 run)
    else $error("call frame not two bytes");

  a_int_frame: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_14]
    run && ctl_i.intr |=> state == mcu_space_pkg::S_PUSH [*3] ##1 run)
    else $error("interrupt frame not three bytes");

  a_interrupt_return_flags: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_14]
    pop_cmd && ctl_i.interrupt_return |-> ##2 flags_load_o)
    else $error("flags not restored by interrupt return");

  a_work_form: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_11]
    access && !req_i.wreg && in_work |=> addr_err_o && !rvalid_o)
    else $error("plain working-area address accepted");

  a_pair_odd: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_12]
    access && req_i.pair && ea[0] |=> addr_err_o)
    else $error("odd pair address accepted");

  a_sp_load: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_16]
    wr_sp |=> sp == $past(req_i.wdata[7:0]))
    else $error("pointer write lost");

  a_opt_skip: assert property (@(posedge clk_i) disable iff (!nrst_i)  // see [RULE_04]
    fetch_opt |=> addr_err_o && prog_addr_o == mcu_space_pkg::RESET_ENTRY)
    else $error("option cell executed");

endmodule : mcu_address_space

// file: core/mcu_space_pkg.sv
/*
  Shared constants and carriers for the address-space and stack block.
  Assumes one system clock and a CPU core on the same clock.
*/
package mcu_space_pkg;
  // Program memory map
  localparam int        PROG_AW    = 12;
  localparam logic [11:0] PROG_TOP  = 12'hFFF;
  localparam logic [11:0] VEC_TOP   = 12'h0FF;
  localparam logic [11:0] OPT_FIRST = 12'h03C;
  localparam logic [11:0] OPT_LAST  = 12'h03F;
  localparam logic [11:0] OPT_LOW_VOLTAGE_RESET = 12'h03E;
  localparam logic [11:0] OPT_OSC   = 12'h03F;
  localparam logic [11:0] RESET_ENTRY = 12'h100;
  localparam logic [7:0]  OPT_ERASED = 8'hFF;
  // Register file map
  localparam logic [7:0]  GP_TOP    = 8'hBF;
  localparam logic [7:0]  WORK_BASE = 8'hC0;
  localparam logic [7:0]  WORK_TOP  = 8'hCF;
  localparam logic [7:0]  SP_ADDR   = 8'hD9;
  localparam int          GP_COUNT  = 208;
  localparam int          CTRL_COUNT = 34;
  // Stack frame sizes in bytes
  localparam logic [1:0]  CALL_BYTES = 2'h2;
  localparam logic [1:0]  INT_BYTES  = 2'h3;

  // One register-bus request from the core
  typedef struct packed {
    logic [7:0]  addr;   // Direct address, or working number in [3:0]
    logic [15:0] wdata;  // Pair data, MSB first; single byte in [7:0]
    logic        wr;
    logic        rd;
    logic        wreg;   // Working-register addressing form
    logic        pair;   // 16-bit pair access
  } reg_req_t;

  // Fetch and flow control from the core
  typedef struct packed {
    logic        fetch;  // Advance to next program byte
    logic        jump;
    logic        call;
    logic        subroutine_return;
    logic        intr;
    logic        interrupt_return;
    logic [11:0] target;
  } ctl_req_t;

  typedef enum logic [4:0] {
    S_BOOT_E = 5'h01,
    S_BOOT_F = 5'h02,
    S_RUN    = 5'h04,
    S_PUSH   = 5'h08,
    S_POP    = 5'h10
  } state_t;
endpackage : mcu_space_pkg

// file: test/prog_rom_model.sv
/*
  Program ROM model standing beside the address-space block.
  Assumes a combinational read of the program address, same cycle.
*/
`timescale 1ns/10ps

module prog_rom_model (
  input  wire logic [11:0] addr_i,  // Program address from the block
  output logic      [7:0]  data_o   // Byte at that address
);
  // Option cells: 3E enables the supply monitor, 3F picks RC oscillator
  wire       is_supply = (addr_i == 12'h03E);
  wire       is_osc    = (addr_i == 12'h03F);
  wire       is_fill   = (addr_i == 12'h03C) || (addr_i == 12'h03D);
  // Other bytes echo the low address so a wrong fetch shows up
  assign data_o = is_supply ? 8'h7F : is_osc ? 8'hFE : is_fill ? 8'hFF : addr_i[7:0];
endmodule : prog_rom_model

// file: test/testbench.sv
/*
  Self-checking bench for the address-space block.
  Assumes the package is compiled first and the ROM model is present.
*/
`timescale 1ns/10ps

module testbench;
  logic                    clk_i;
  logic                    nrst_i;
  mcu_space_pkg::reg_req_t req;
  mcu_space_pkg::ctl_req_t ctl;
  logic [7:0]              flags, rom, fout, opt_supply, opt_osc;
  logic [15:0]             rdata;
  logic [11:0]             prog_addr;
  logic                    rvalid, fload, busy, err;
  logic [16:0]             notes[$];       // Expected {error, data}, oldest first
  logic [7:0]              flag_notes[$];  // Expected restored flags, oldest first
  logic [7:0]              addr;           // Random general-space address
  logic [31:0]             seed;
  int                      fail_count;
  int                      total_checks;

  mcu_address_space dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .ctl_i(ctl), .flags_i(flags),
    .rom_data_i(rom), .rdata_o(rdata), .rvalid_o(rvalid), .prog_addr_o(prog_addr), .flags_o(fout),
    .flags_load_o(fload), .busy_o(busy), .addr_err_o(err), .option_low_voltage_reset_o(opt_supply),
    .option_osc_o(opt_osc));
  prog_rom_model rom_model (.addr_i(prog_addr), .data_o(rom));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // Shared count and report behind the typed compare tasks
  task automatic compare(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  // Register bus answer as {error, read data}
  task automatic check_answer(input logic [16:0] got, input logic [16:0] exp);
    compare(got, exp);
  endtask : check_answer

  // Flags restored by an interrupt return
  task automatic check_flags(input logic [7:0] got, input logic [7:0] exp);
    compare({9'h0, got}, {9'h0, exp});
  endtask : check_flags

  // Program address on the fetch side
  task automatic check_addr(input logic [11:0] exp);
    compare({5'h0, prog_addr}, {5'h0, exp});
  endtask : check_addr

  // Level outputs and bench bookkeeping
  task automatic check_level(input logic [15:0] got, input logic [15:0] exp);
    compare({1'b0, got}, {1'b0, exp});
  endtask : check_level

  // One register bus request; a read or refused access leaves a note
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic wr_form,
                     input logic pr, input logic note, input logic [16:0] exp);
    @(negedge clk_i);
    if (note) notes.push_back(exp);
    req <= '{a, d, w, ~w, wr_form, pr};
    @(negedge clk_i);
    req <= '0;
  endtask : bus

  // One flow command {fetch, jump, call, subroutine return, interrupt, interrupt return}; waits for the frame
  task automatic cmd(input logic [5:0] sel, input logic [11:0] tgt);
    int n;
    @(negedge clk_i);
    ctl <= mcu_space_pkg::ctl_req_t'({sel, tgt});
    @(negedge clk_i);
    ctl <= '0;
    n = 0;
    while (busy !== 1'b0 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 8) check_level(16'h1, 16'h0);
  endtask : cmd

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and result monitor
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end

  // Results are settled 1 ns after the edge
  always @(posedge clk_i) begin
    #1;
    if (rvalid === 1'b1 || err === 1'b1)
      check_answer({err, err ? 16'h0 : rdata}, notes.size() ? notes.pop_front() : 17'h1FFFF);
    if (fload === 1'b1) begin
      if (flag_notes.size()) check_flags(fout, flag_notes.pop_front());
      else check_level(16'h1, 16'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst_i = 1'b0;
    req = '0;
    ctl = '0;
    flags = 8'h00;
    addr = 8'h00;
    fail_count = 0;
    total_checks = 0;
    seed = 32'hC226;
    repeat (10) @(negedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    check_addr(mcu_space_pkg::RESET_ENTRY);
    check_level({opt_supply, opt_osc}, 16'h7FFE);
    check_level({15'h0, busy}, 16'h0000);
    // Random bytes in general space, top location included
    for (int i = 0; i < 9; i++) begin
      seed = xs(seed);
      addr = (i == 8) ? mcu_space_pkg::GP_TOP : seed[7:0] % 8'hC0;
      bus(1'b1, addr, {8'h00, seed[15:8]}, 1'b0, 1'b0, 1'b0, 17'h0);
      bus(1'b0, addr, 16'h0, 1'b0, 1'b0, 1'b1, {9'h0, seed[15:8]});
    end
    // Working registers only through the working form, top one included
    bus(1'b1, 8'h02, 16'h005A, 1'b1, 1'b0, 1'b0, 17'h0);
    bus(1'b1, 8'hC2, 16'h0011, 1'b0, 1'b0, 1'b1, 17'h10000);
    bus(1'b0, 8'hC3, 16'h0, 1'b0, 1'b0, 1'b1, 17'h10000);
    bus(1'b0, 8'h02, 16'h0, 1'b1, 1'b0, 1'b1, 17'h005A);
    bus(1'b1, 8'h0F, 16'h00A5, 1'b1, 1'b0, 1'b0, 17'h0);
    bus(1'b0, 8'h0F, 16'h0, 1'b1, 1'b0, 1'b1, 17'h00A5);
    // Pairs: MSB at the even place, odd start refused
    bus(1'b1, 8'h40, 16'h1234, 1'b0, 1'b1, 1'b0, 17'h0);
    bus(1'b0, 8'h40, 16'h0, 1'b0, 1'b0, 1'b1, 17'h0012);
    bus(1'b0, 8'h41, 16'h0, 1'b0, 1'b0, 1'b1, 17'h0034);
    bus(1'b0, 8'h40, 16'h0, 1'b0, 1'b1, 1'b1, 17'h1234);
    bus(1'b1, 8'h41, 16'hABCD, 1'b0, 1'b1, 1'b1, 17'h10000);
    bus(1'b0, 8'hD0, 16'h0, 1'b0, 1'b0, 1'b1, 17'h0000);
    // Call and return through the stack, pointer loaded as software must
    bus(1'b1, 8'hD9, 16'h00C0, 1'b0, 1'b0, 1'b0, 17'h0);
    bus(1'b0, 8'hD9, 16'h0, 1'b0, 1'b0, 1'b1, 17'h00C0);
    cmd(6'b010000, 12'h123);
    cmd(6'b001000, 12'h456);
    check_addr(12'h456);
    bus(1'b0, 8'hBF, 16'h0, 1'b0, 1'b0, 1'b1, 17'h0023);
    bus(1'b0, 8'hBE, 16'h0, 1'b0, 1'b0, 1'b1, 17'h0001);
    bus(1'b0, 8'hD9, 16'h0, 1'b0, 1'b0, 1'b1, 17'h00BE);
    cmd(6'b000100, 12'h000);
    check_addr(12'h123);
    bus(1'b0, 8'hD9, 16'h0, 1'b0, 1'b0, 1'b1, 17'h00C0);
    // Interrupt frame with random flags
    seed = xs(seed);
    flags <= seed[7:0];
    cmd(6'b000010, 12'h200);
    check_addr(12'h200);
    bus(1'b0, 8'hBD, 16'h0, 1'b0, 1'b0, 1'b1, {9'h0, seed[7:0]});
    flag_notes.push_back(seed[7:0]);
    cmd(6'b000001, 12'h000);
    check_addr(12'h123);
    // Pointer wraps below zero
    bus(1'b1, 8'hD9, 16'h0000, 1'b0, 1'b0, 1'b0, 17'h0);
    cmd(6'b001000, 12'h300);
    bus(1'b0, 8'hD9, 16'h0, 1'b0, 1'b0, 1'b1, 17'h00FE);
    // Fetch wraps at the top and skips option cells
    cmd(6'b010000, 12'hFFF);
    cmd(6'b100000, 12'h000);
    check_addr(12'h000);
    cmd(6'b010000, 12'h03C);
    notes.push_back(17'h10000);
    cmd(6'b100000, 12'h000);
    check_addr(mcu_space_pkg::RESET_ENTRY);
    // Second reset in mid-run: options erased while held, then read again
    nrst_i <= 1'b0;
    @(negedge clk_i);
    check_level({opt_supply, opt_osc}, 16'hFFFF);
    check_level({15'h0, busy}, 16'h0001);
    nrst_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    check_addr(mcu_space_pkg::RESET_ENTRY);
    check_level({opt_supply, opt_osc}, 16'h7FFE);
    repeat (3) @(negedge clk_i);
    check_level({15'h0, notes.size() == 0 && flag_notes.size() == 0}, 16'h0001);
    wrap_up();
  end
endmodule : testbench
